/* File: design/cse_pkg.sv */
// package: register map, field positions, reset values and timing counts
package cse_pkg;
   // ----------------------------------------------------------------
   // clock
   // ----------------------------------------------------------------
   localparam longint CSE_CLK_HZ = 20_000_000;
   localparam int CSE_CLK_NS = 50;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CSE_OFS_ONE = 8'h00;
   localparam logic [7:0] CSE_OFS_TWO = 8'h04;
   localparam logic [7:0] CSE_OFS_THREE = 8'h08;
   localparam logic [7:0] CSE_OFS_FOUR = 8'h0c;
   localparam logic [7:0] CSE_OFS_DCFG = 8'h10;
   localparam logic [7:0] CSE_OFS_ENP = 8'h14;
   localparam logic [7:0] CSE_OFS_ENN = 8'h18;
   localparam logic [7:0] CSE_OFS_SWAP = 8'h1c;
   localparam logic [7:0] CSE_OFS_STP = 8'h20;
   localparam logic [7:0] CSE_OFS_STN = 8'h24;
   localparam logic [7:0] CSE_OFS_CMD = 8'h28;
   localparam logic [7:0] CSE_OFS_STAT = 8'h2c;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CSE_RATE_LSB = 0;
   localparam int CSE_REFINT_BIT = 5;
   localparam int CSE_PDBIAS_BIT = 2;
   localparam int CSE_SINGLE_BIT = 3;
   localparam int CSE_CPD_BIT = 1;
   localparam int CSE_TH_LSB = 5;
   localparam int CSE_EXC_BIT = 4;
   localparam int CSE_ICUR_LSB = 2;
   localparam int CSE_FREQ_LSB = 0;
   localparam int CSE_CMD_START = 0;
   localparam int CSE_CMD_STOP = 1;
   localparam logic [1:0] CSE_FREQ_LOW = 2'h1;
   localparam logic [1:0] CSE_FREQ_HIGH = 2'h2;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CSE_RST_ONE = 8'h06;
   localparam logic [7:0] CSE_RST_FOUR = 8'h00;
   localparam logic [7:0] CSE_RST_ZERO = 8'h00;
   // ----------------------------------------------------------------
   // timing, in master clock periods unless stated
   // ----------------------------------------------------------------
   localparam int CSE_QUAL_CLKS = 2;
   localparam int CSE_REFRESH_CLKS = 4;
   localparam int CSE_SETTLED_PULSES = 4;
   localparam int CSE_BASE_PERIOD = 128;
   localparam int CSE_SET_0 = 521;
   localparam int CSE_SET_1 = 1033;
   localparam int CSE_SET_2 = 2057;
   localparam int CSE_SET_3 = 4105;
   localparam int CSE_SET_4 = 8201;
   localparam int CSE_SET_5 = 16393;
   localparam int CSE_SET_6 = 32777;
   localparam longint CSE_AC_LOW_MHZ = 7800;
   localparam longint CSE_AC_HIGH_MHZ = 31200;
   localparam int CSE_AC_LOW_HALF = int'(CSE_CLK_HZ * 1000
      / (2 * CSE_AC_LOW_MHZ));
   localparam int CSE_AC_HIGH_HALF = int'(CSE_CLK_HZ * 1000
      / (2 * CSE_AC_HIGH_MHZ));
   // ----------------------------------------------------------------
   // pacing states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CSE_IDLE = 3'b001,
      CSE_SETTLE = 3'b010,
      CSE_RUN = 3'b100
   } cse_pace_t;
endpackage : cse_pkg

/* File: design/cse_pace_if.sv */
// interface: control core to conversion pacing timer
`timescale 1ns/1ps
interface cse_pace_if;
   logic start_evt;
   logic stop_req;
   logic single;
   logic taken;
   logic [2:0] rate;
   logic ready_n;
   logic running;
   logic [2:0] pulses;
   modport ctrl (output start_evt, stop_req, single, taken, rate,
                 input ready_n, running, pulses);
   modport pace (input start_evt, stop_req, single, taken, rate,
                 output ready_n, running, pulses);
endinterface : cse_pace_if

/* File: design/cse_pace.sv */
// conversion pacing: settling delay, data period and ready strobe
`timescale 1ns/1ps
module cse_pace #(
   parameter int CW = 16,
   parameter int SET0 = cse_pkg::CSE_SET_0,
   parameter int SET1 = cse_pkg::CSE_SET_1,
   parameter int SET2 = cse_pkg::CSE_SET_2,
   parameter int SET3 = cse_pkg::CSE_SET_3,
   parameter int SET4 = cse_pkg::CSE_SET_4,
   parameter int SET5 = cse_pkg::CSE_SET_5,
   parameter int SET6 = cse_pkg::CSE_SET_6,
   parameter int BASE = cse_pkg::CSE_BASE_PERIOD
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   cse_pace_if.pace pif
);
   import cse_pkg::*;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [CW-1:0] settle_len(input logic [2:0] r);
      case (r)
         3'h0: settle_len = CW'(SET0);
         3'h1: settle_len = CW'(SET1);
         3'h2: settle_len = CW'(SET2);
         3'h3: settle_len = CW'(SET3);
         3'h4: settle_len = CW'(SET4);
         3'h5: settle_len = CW'(SET5);
         default: settle_len = CW'(SET6);
      endcase
   endfunction : settle_len
   function automatic logic [CW-1:0] period_len(input logic [2:0] r);
      period_len = CW'(BASE) << r;
   endfunction : period_len
   localparam logic [CW-1:0] REFRESH = CW'(CSE_REFRESH_CLKS);
   localparam logic [2:0] SAT = 3'(CSE_SETTLED_PULSES);
   cse_pace_t state_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] age_q;
   logic [2:0] rate_q;
   logic ready_n_q;
   logic stop_q;
   logic [2:0] pulses_q;
   logic fin;
   assign fin = (cnt_q == '0) && !pif.start_evt;
   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   // rate is frozen at start so a mid-run write cannot stretch a period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CSE_IDLE;
         cnt_q <= '0;
         rate_q <= 3'h0;
         ready_n_q <= 1'b1;
      end else if (pif.start_evt) begin
         state_q <= CSE_SETTLE;
         rate_q <= pif.rate;
         cnt_q <= settle_len(pif.rate) - CW'(1);
         ready_n_q <= 1'b1;
      end else begin
         case (state_q)
            CSE_SETTLE: begin
               cnt_q <= cnt_q - CW'(1);
               if (cnt_q == '0) begin
                  ready_n_q <= 1'b0;
                  cnt_q <= period_len(rate_q) - CW'(1);
                  state_q <= (pif.single || stop_q) ? CSE_IDLE : CSE_RUN;
               end
            end
            CSE_RUN: begin
               cnt_q <= cnt_q - CW'(1);
               if (cnt_q == '0) begin
                  ready_n_q <= 1'b0;
                  cnt_q <= period_len(rate_q) - CW'(1);
                  if (stop_q || pif.single) begin
                     state_q <= CSE_IDLE;
                  end
               end else if (cnt_q == REFRESH && !ready_n_q) begin
                  ready_n_q <= 1'b1;
               end else if (pif.taken) begin
                  ready_n_q <= 1'b1;
               end
            end
            // halted: no falling edge until the next start
            default: begin
               state_q <= CSE_IDLE;
            end
         endcase
      end
   end
   // a stop lets the conversion in progress complete
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_q <= 1'b0;
      end else if (pif.start_evt) begin
         stop_q <= 1'b0;
      end else if (pif.stop_req) begin
         stop_q <= 1'b1;
      end else if (state_q == CSE_IDLE) begin
         stop_q <= 1'b0;
      end
   end
   // results since restart; the fourth one is past any 3-period step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulses_q <= 3'h0;
      end else if (pif.start_evt) begin
         pulses_q <= 3'h0;
      end else if (state_q != CSE_IDLE && fin && pulses_q != SAT) begin
         pulses_q <= pulses_q + 3'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_q <= '0;
      end else if (pif.start_evt) begin
         age_q <= '0;
      end else if (state_q == CSE_SETTLE) begin
         age_q <= age_q + CW'(1);
      end
   end
   assign pif.ready_n = ready_n_q;
   assign pif.running = (state_q != CSE_IDLE);
   assign pif.pulses = pulses_q;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_start_raises: assert property (@(posedge pclk) disable iff (!presetn)
      pif.start_evt |=> ready_n_q ##1 ready_n_q)
      else $error("ready not held high after start");
   a_settle_len: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == CSE_SETTLE && fin)
      |-> age_q == settle_len(rate_q) - CW'(1))
      else $error("settling length wrong for rate");
   a_refresh_width: assert property (@(posedge pclk)
      disable iff (!presetn || pif.start_evt)
      (state_q == CSE_RUN && !ready_n_q && cnt_q == REFRESH)
      |=> ready_n_q [*4] ##1 !ready_n_q)
      else $error("refresh pulse not four clocks");
   a_period_reload: assert property (@(posedge pclk)
      disable iff (!presetn)
      (state_q == CSE_RUN && fin && !stop_q && !pif.single)
      |=> cnt_q == period_len(rate_q) - CW'(1))
      else $error("data period reload wrong");
   a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == CSE_IDLE && !pif.start_evt)
      |=> !$fell(ready_n_q))
      else $error("ready fell while halted");
   a_single_stops: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == CSE_SETTLE && fin && pif.single)
      |=> state_q == CSE_IDLE ##1 !ready_n_q)
      else $error("one-conversion mode kept running");
endmodule : cse_pace

/* File: design/cse_top.sv */
// conversion start control and electrode-disconnect settings, APB slave
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - start on qualified pin high or command
// - halted means no ready falling edges
// - continuous or one-conversion mode select bit
// - start raises ready until settling ends
// - settling derived from clock and rate code
// - then ready falls every data period
// - unread result gives four-clock ready pulse
// - fourth result after step is settled
// - shared pin aligns all devices' timing
// - per-channel sense enables, excitation can disable
// - swap bit exchanges pull-up and pull-down
// - two-bit excitation current magnitude field
// - three-bit threshold drives comparator DAC
// - comparator status registers, also in stream
// - power-down bit turns comparators off
// - ac excitation alternates at 7.8/31.2 Hz
// - bias comparator shares negative threshold field
// - bias reference internal or external select
// - bias amplifier power-down bit
// - settling counts per rate code table
// - start takes effect immediately, stop after the conversion in progress
module cse_top #(
   parameter int NCH = 8,
   parameter int SET4 = cse_pkg::CSE_SET_4,
   parameter int SET5 = cse_pkg::CSE_SET_5,
   parameter int SET6 = cse_pkg::CSE_SET_6,
   parameter int BASE = cse_pkg::CSE_BASE_PERIOD,
   parameter int AC_LOW_HALF = cse_pkg::CSE_AC_LOW_HALF,
   parameter int AC_HIGH_HALF = cse_pkg::CSE_AC_HIGH_HALF
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // conversion control
   input wire logic start_pin,
   output logic result_ready_n,
   // disconnect detection
   input wire logic [NCH-1:0] comp_pos_in,
   input wire logic [NCH-1:0] comp_neg_in,
   output logic [NCH-1:0] detect_enable_pos,
   output logic [NCH-1:0] detect_enable_neg,
   output logic [NCH-1:0] excite_on_pos,
   output logic [NCH-1:0] excite_on_neg,
   output logic [NCH-1:0] excitation_swap,
   output logic [1:0] excite_current_sel,
   output logic excite_sink_phase,
   output logic [2:0] comparator_threshold,
   output logic [2:0] bias_comp_threshold,
   output logic comparator_powerdown,
   output logic [23:0] stream_status,
   // bias loop
   output logic loop_ref_internal,
   output logic loop_amp_powerdown_n
);
   import cse_pkg::*;
   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [7:0] one_q;
   logic [7:0] two_q;
   logic [7:0] three_q;
   logic [7:0] four_q;
   logic [7:0] dcfg_q;
   logic [NCH-1:0] enp_q;
   logic [NCH-1:0] enn_q;
   logic [NCH-1:0] swap_q;
   logic [NCH-1:0] stp_q;
   logic [NCH-1:0] stn_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic wr_acc;
   logic rd_acc;
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         CSE_OFS_ONE, CSE_OFS_TWO, CSE_OFS_THREE, CSE_OFS_FOUR,
         CSE_OFS_DCFG, CSE_OFS_ENP, CSE_OFS_ENN, CSE_OFS_SWAP,
         CSE_OFS_STP, CSE_OFS_STN, CSE_OFS_CMD, CSE_OFS_STAT:
            mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped
   assign wr_acc = psel && penable && pwrite && mapped(paddr);
   assign rd_acc = psel && penable && !pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         one_q <= CSE_RST_ONE;
         two_q <= CSE_RST_ZERO;
         three_q <= CSE_RST_ZERO;
         four_q <= CSE_RST_FOUR;
         dcfg_q <= CSE_RST_ZERO;
         enp_q <= '0;
         enn_q <= '0;
         swap_q <= '0;
      end else if (wr_acc) begin
         case (paddr)
            CSE_OFS_ONE: one_q <= pwdata[7:0];
            CSE_OFS_TWO: two_q <= pwdata[7:0];
            CSE_OFS_THREE: three_q <= pwdata[7:0];
            CSE_OFS_FOUR: four_q <= pwdata[7:0];
            CSE_OFS_DCFG: dcfg_q <= pwdata[7:0];
            CSE_OFS_ENP: enp_q <= pwdata[NCH-1:0];
            CSE_OFS_ENN: enn_q <= pwdata[NCH-1:0];
            CSE_OFS_SWAP: swap_q <= pwdata[NCH-1:0];
            default: one_q <= one_q;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // comparator status capture
   // ----------------------------------------------------------------
   // powered-down comparators report clear so stale flags never linger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stp_q <= '0;
         stn_q <= '0;
      end else if (four_q[CSE_CPD_BIT]) begin
         stp_q <= '0;
         stn_q <= '0;
      end else begin
         stp_q <= comp_pos_in & enp_q;
         stn_q <= comp_neg_in & enn_q;
      end
   end
   // ----------------------------------------------------------------
   // start qualification and commands
   // ----------------------------------------------------------------
   cse_pace_if pif ();
   logic [CSE_QUAL_CLKS-2:0] pin_hist_q;
   logic pin_qual;
   logic pin_lvl_q;
   logic cmd_start;
   logic cmd_stop;
   // pin counts only after two consecutive high samples, so every
   // device on a shared pin starts on the same clock edge
   assign pin_qual = start_pin && (&pin_hist_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_hist_q <= '0;
         pin_lvl_q <= 1'b0;
      end else begin
         // newest sample enters at bit 0; the oldest drops off the top
         pin_hist_q <= (CSE_QUAL_CLKS-1)'({pin_hist_q, start_pin});
         pin_lvl_q <= pin_qual;
      end
   end
   // commands act at the bus write edge; the pin is expected low then
   assign cmd_start = wr_acc && paddr == CSE_OFS_CMD
      && pwdata[CSE_CMD_START];
   assign cmd_stop = wr_acc && paddr == CSE_OFS_CMD
      && pwdata[CSE_CMD_STOP];
   assign pif.start_evt = (pin_qual && !pin_lvl_q) || cmd_start;
   assign pif.stop_req = (!pin_qual && pin_lvl_q) || cmd_stop;
   assign pif.single = four_q[CSE_SINGLE_BIT];
   assign pif.rate = one_q[CSE_RATE_LSB +: 3];
   assign pif.taken = rd_acc && paddr == CSE_OFS_STP;
   cse_pace #(
      .SET4(SET4),
      .SET5(SET5),
      .SET6(SET6),
      .BASE(BASE)
   ) u_pace (
      .pclk(pclk),
      .presetn(presetn),
      .pif(pif)
   );
   // ----------------------------------------------------------------
   // ac excitation alternation
   // ----------------------------------------------------------------
   logic [20:0] ac_cnt_q;
   logic [20:0] ac_half;
   logic ac_on;
   logic phase_q;
   assign ac_on = dcfg_q[CSE_FREQ_LSB +: 2] == CSE_FREQ_LOW
      || dcfg_q[CSE_FREQ_LSB +: 2] == CSE_FREQ_HIGH;
   assign ac_half = (dcfg_q[CSE_FREQ_LSB +: 2] == CSE_FREQ_LOW)
      ? 21'(AC_LOW_HALF) : 21'(AC_HIGH_HALF);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ac_cnt_q <= '0;
         phase_q <= 1'b0;
      end else if (!ac_on) begin
         ac_cnt_q <= '0;
         phase_q <= 1'b0;
      end else if (ac_cnt_q >= ac_half - 21'h1) begin
         ac_cnt_q <= '0;
         phase_q <= !phase_q;
      end else begin
         ac_cnt_q <= ac_cnt_q + 21'h1;
      end
   end
   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // read data is registered in the setup phase, ready for the access
   always_comb begin
      rdata_d = 32'h0;
      case (paddr)
         CSE_OFS_ONE: rdata_d[7:0] = one_q;
         CSE_OFS_TWO: rdata_d[7:0] = two_q;
         CSE_OFS_THREE: rdata_d[7:0] = three_q;
         CSE_OFS_FOUR: rdata_d[7:0] = four_q;
         CSE_OFS_DCFG: rdata_d[7:0] = dcfg_q;
         CSE_OFS_ENP: rdata_d[NCH-1:0] = enp_q;
         CSE_OFS_ENN: rdata_d[NCH-1:0] = enn_q;
         CSE_OFS_SWAP: rdata_d[NCH-1:0] = swap_q;
         CSE_OFS_STP: rdata_d[NCH-1:0] = stp_q;
         CSE_OFS_STN: rdata_d[NCH-1:0] = stn_q;
         CSE_OFS_STAT: rdata_d[4:0] = {pif.pulses, pif.running,
                                       pif.ready_n};
         default: rdata_d = 32'h0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0;
      end else if (psel && !penable) begin
         rdata_q <= rdata_d;
      end
   end
   assign prdata = rdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic [23:0] stream_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stream_q <= 24'hc00000;
      end else begin
         stream_q <= {4'hc, 8'(stp_q), 8'(stn_q), 4'h0};
      end
   end
   assign stream_status = stream_q;
   assign result_ready_n = pif.ready_n;
   assign detect_enable_pos = enp_q;
   assign detect_enable_neg = enn_q;
   // sensing may stay on while the excitation bit is cleared
   assign excite_on_pos = enp_q & {NCH{dcfg_q[CSE_EXC_BIT]}};
   assign excite_on_neg = enn_q & {NCH{dcfg_q[CSE_EXC_BIT]}};
   assign excitation_swap = swap_q;
   assign excite_current_sel = dcfg_q[CSE_ICUR_LSB +: 2];
   assign excite_sink_phase = phase_q;
   assign comparator_threshold = dcfg_q[CSE_TH_LSB +: 3];
   assign bias_comp_threshold = dcfg_q[CSE_TH_LSB +: 3];
   assign comparator_powerdown = four_q[CSE_CPD_BIT];
   assign loop_ref_internal = two_q[CSE_REFINT_BIT];
   assign loop_amp_powerdown_n = three_q[CSE_PDBIAS_BIT];
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_pin_qualify: assert property (@(posedge pclk) disable iff (!presetn)
      (pif.start_evt && !cmd_start) |-> start_pin && $past(start_pin))
      else $error("pin start taken without two high samples");
   a_cmd_start: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_start |=> pif.running && result_ready_n)
      else $error("start command did not start conversions");
   a_pd_clears: assert property (@(posedge pclk) disable iff (!presetn)
      four_q[CSE_CPD_BIT] |=> stp_q == '0 && stn_q == '0)
      else $error("status not cleared under comparator power-down");
   a_ac_still: assert property (@(posedge pclk) disable iff (!presetn)
      !ac_on |=> !phase_q && ac_cnt_q == '0)
      else $error("excitation alternated with ac off");
endmodule : cse_top

/* File: testbench/cse_host_model.sv */
// host controller model driving the start pin level
`timescale 1ns/1ps
module cse_host_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request from bench, pin to device
   input wire logic run_req,
   output logic start_pin
);
   // the pin follows a held request, so a high lasts two clocks or more
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) start_pin <= 1'b0;
      else start_pin <= run_req;
   end
endmodule : cse_host_model

/* File: testbench/test_cse_top.sv */
// self-checking bench: start pacing and detection settings over apb
`timescale 1ns/1ps
module test_cse_top;
   import cse_pkg::*;
   localparam int S4 = 40;
   localparam int BS = 16;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} cse_row_t;
   cse_row_t rows[6];
   logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic run_req = 0, start_pin, rdy_n, lref, lamp, cpd, e;
   logic [7:0] paddr = 0, cz = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [2:0] th, bth;
   logic [23:0] ss;
   logic [1:0] ics;
   int fails = 0, comparisons = 0, cyc = 0, k, k2;
   cse_host_model host (.pclk(pclk), .presetn(presetn), .run_req(run_req),
      .start_pin(start_pin));
   cse_top #(.SET4(S4), .SET5(50), .SET6(60), .BASE(BS), .AC_LOW_HALF(20),
      .AC_HIGH_HALF(10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .start_pin(start_pin), .result_ready_n(rdy_n), .comp_pos_in(cz),
      .comp_neg_in(cz), .detect_enable_pos(), .detect_enable_neg(),
      .excite_on_pos(), .excite_on_neg(), .excitation_swap(),
      .excite_current_sel(ics), .excite_sink_phase(),
      .comparator_threshold(th), .bias_comp_threshold(bth),
      .comparator_powerdown(cpd), .stream_status(ss),
      .loop_ref_internal(lref), .loop_amp_powerdown_n(lamp));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   // one transfer; an idle edge after it so the next setup never collides
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wait_lvl(input logic v, input int lim, output int n);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (rdy_n !== v && n < lim);
   endtask : wait_lvl
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      rows = '{'{CSE_OFS_ONE, 32'h04, 32'h04}, '{CSE_OFS_TWO, 32'h20, 32'h20},
         '{CSE_OFS_THREE, 32'h04, 32'h04}, '{CSE_OFS_FOUR, 32'h02, 32'h02},
         '{CSE_OFS_DCFG, 32'ha4, 32'ha4}, '{CSE_OFS_STP, 32'hff, 32'h00}};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(rdy_n, 1'b1);
      apb(1'b0, CSE_OFS_ONE, 32'h0);
      chk(rd, CSE_RST_ONE);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].r);
      end
      chk(lref, 1'b1);
      chk(lamp, 1'b1);
      chk(cpd, 1'b1);
      chk(th, 3'h5);
      chk(bth, 3'h5);
      chk(ics, 2'h1);
      chk(ss, 24'hc00000);
      apb(1'b0, 8'h40, 32'h0);
      chk(e, 1'b1);
      chk(rd, 32'h0);
      run_req <= 1'b1;
      wait_lvl(1'b0, 2000, k);
      chk(k, S4 + 4);
      wait_lvl(1'b1, 2000, k);
      wait_lvl(1'b0, 2000, k2);
      chk(k2, 4);
      chk(k + k2, BS << 4);
      @(posedge pclk);
      run_req <= 1'b0;
      repeat (600) @(posedge pclk);
      wait_lvl(1'b1, 600, k);
      chk(k, 600);
      apb(1'b1, CSE_OFS_FOUR, 32'h0a);
      apb(1'b1, CSE_OFS_CMD, 32'h01);
      wait_lvl(1'b0, 2000, k);
      chk(k, S4);
      apb(1'b0, CSE_OFS_STP, 32'h0);
      wait_lvl(1'b1, 600, k);
      chk(k, 600);
      apb(1'b0, CSE_OFS_STAT, 32'h0);
      chk(rd, 32'h04);
      end_sim();
   end
endmodule : test_cse_top
